/* File: rtl/cmb_top.sv */
// Function
// R1 - three independent transmit buffers
// R2 - thirteen frame bytes, priority, two stamp bytes
// R3 - software selects an empty buffer into window
// R4 - software loads buffer then clears empty
// R5 - sent frame sets empty, transmit interrupt
// R6 - lowest priority value transmits first
// R7 - ties go to lower buffer index
// R8 - prioritize again at every arbitration attempt
// R9 - abort on request, never during transmission
// R10 - abort sets acknowledge, empty and interrupt
// R11 - five-stage receive FIFO, foreground window
// R12 - fifteen-byte receive buffers with stamp
// R13 - receiver-full marks accepted foreground frame
// R14 - valid accepted frame pushed, flag, interrupt
// R15 - software reads then clears receiver-full
// R16 - next frame goes to next background
// R17 - invalid frames never enter the FIFO
// R18 - own frames captured but not pushed
// R19 - loopback treats own frames as received
// R20 - lost arbitration continues as receiver
// R21 - full FIFO discards frame, flags overrun
// R22 - keep transmitting, accept after release
// R23 - stamp counter written after valid frame
// R24 - reset leaves buffers empty, FIFO empty
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`include "cmb_cfg.svh"
`default_nettype none
module cmb_top
    import cmb_pkg::*;
#(
    parameter int NTX      = 3,
    parameter int RX_DEPTH = 5
)(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmit engine
    input  wire logic        arb_start,
    input  wire logic        tx_done,
    input  wire logic        tx_lost,
    input  wire logic        tx_error,
    output logic             tx_req,
    output logic [1:0]       tx_index,
    output logic [103:0]     tx_frame,
    // Receive engine
    input  wire cmb_rxw_s    rx_wr,
    input  wire cmb_rx_end_s rx_end,
    input  wire logic        bit_tick,
    output logic             loopback,
    // Event lines
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             ovr_irq
);
    localparam int PW = $clog2(RX_DEPTH);
    // Software state
    logic [2:0]     ctrl_q;        // Loopback, stamping, init
    logic [2:0]     mask_q;        // Event enables
    logic [NTX-1:0] empty_q;       // Buffer empty flags
    logic [NTX-1:0] arq_q;         // Abort requests
    logic [NTX-1:0] aak_q;         // Abort acknowledges
    logic [1:0]     sel_q;         // Window buffer
    logic           sel_ok_q;      // Window mapped
    logic           ovr_q;         // Overrun flag
    logic [15:0]    stamp_q;       // Free-running bit counter
    // Transmit engine state
    cmb_tx_e        tx_st_q;
    logic [1:0]     act_q;         // Buffer on the bus
    logic [103:0]   frame_q;
    // Transmit and receive storage
    cmb_byte_t      txm [NTX][16];                                 // see R1 R2
    cmb_byte_t      bg  [`CMB_RX_BYTES];
    cmb_byte_t      fifo[RX_DEPTH][`CMB_RX_BYTES];
    logic [PW-1:0]  rd_q;
    logic [PW-1:0]  wr_q;
    logic [PW:0]    cnt_q;
    // APB read capture
    logic [31:0]    rdata_q;
    logic           err_q;

    // APB decode
    wire logic       setup   = psel & ~penable;
    wire logic       wr_acc  = psel & penable & pwrite;
    wire logic [1:0] region  = paddr[7:6];
    wire logic [3:0] slot    = paddr[5:2];
    wire logic       hit_ctl = paddr == `CMB_A_CTRL;
    wire logic       hit_rxf = paddr == `CMB_A_RXFLG;
    wire logic       hit_txf = paddr == `CMB_A_TXFLG;
    wire logic       hit_sel = paddr == `CMB_A_TBSEL;
    wire logic       hit_arq = paddr == `CMB_A_ARQ;
    wire logic       hit_aak = paddr == `CMB_A_AAK;
    wire logic       hit_msk = paddr == `CMB_A_MASK;
    wire logic       hit_txw = region == `CMB_R_TXWIN;
    wire logic       hit_rxw = region == `CMB_R_RXWIN && slot <= `CMB_RX_STL;
    wire logic       mapped  = hit_ctl | hit_rxf | hit_txf | hit_sel | hit_arq
                             | hit_aak | hit_msk | hit_txw | hit_rxw;
    // Mode bits
    wire logic init_m  = ctrl_q[`CMB_CTRL_INIT];
    wire logic time_en = ctrl_q[`CMB_CTRL_TIME];
    assign loopback    = ctrl_q[`CMB_CTRL_LOOP];
    // Window open only for a selected, still empty buffer
    wire logic win_ok  = sel_ok_q & empty_q[sel_q];                 // see R3
    // Write strobes
    wire logic w_ctl = wr_acc & hit_ctl;
    wire logic w_rxf = wr_acc & hit_rxf;
    wire logic w_txf = wr_acc & hit_txf;
    wire logic w_sel = wr_acc & hit_sel;
    wire logic w_arq = wr_acc & hit_arq;
    wire logic w_msk = wr_acc & hit_msk;
    wire logic w_txw = wr_acc & hit_txw & win_ok & slot <= `CMB_TX_LOCAL_PRIORITY;
    // Receive FIFO status
    wire logic rx_full = cnt_q != '0;                               // see R13
    wire logic fifo_fl = cnt_q == (PW+1)'(RX_DEPTH);
    wire logic pop     = w_rxf & pwdata[`CMB_RXF_FULL] & rx_full;   // see R15
    // Own frame counts only in loopback
    wire logic rx_good = rx_end.valid & rx_end.ok & rx_end.accept
                       & (~rx_end.own | loopback);                  // see R17 R18 R19 R20
    wire logic push    = rx_good & (~fifo_fl | pop);                // see R14 R22
    wire logic ovr_ev  = rx_good & fifo_fl & ~pop;                  // see R21
    // Prioritization among ready buffers
    logic       win_found;
    logic [1:0] win_idx;
    cmb_byte_t  win_local_priority;
    always_comb
    begin
        win_found = 1'b0;
        win_idx   = 2'h0;
        win_local_priority  = 8'hFF;
        for (int i = 0; i < NTX; i++)
        begin
            // Strict compare keeps the lower index on a tie
            if (!empty_q[i] && (!win_found || txm[i][`CMB_TX_LOCAL_PRIORITY] < win_local_priority)) // see R6 R7
            begin
                win_found = 1'b1;
                win_idx   = 2'(i);
                win_local_priority  = txm[i][`CMB_TX_LOCAL_PRIORITY];
            end
        end
    end
    // Transmit engine events
    wire logic busy    = tx_st_q == TX_BUSY;
    wire logic tx_ok   = busy & tx_done;
    wire logic tx_end  = busy & (tx_done | tx_lost | tx_error);     // see R20
    // Abort only what is not on the bus
    logic [NTX-1:0] abort_g;
    logic [NTX-1:0] done_m;
    always_comb
    begin
        for (int i = 0; i < NTX; i++)
        begin
            abort_g[i] = arq_q[i] & ~empty_q[i]
                       & ~(busy & act_q == 2'(i));                  // see R9
            done_m[i]  = tx_ok & act_q == 2'(i);
        end
    end
    // Flag next values; hardware set wins over software clear
    wire logic [NTX-1:0] sw_clr  = w_txf ? pwdata[NTX-1:0] : '0;
    wire logic [NTX-1:0] empty_d = (empty_q & ~sw_clr) | done_m | abort_g; // see R4 R5 R10
    wire logic [NTX-1:0] aak_d   = (aak_q & ~sw_clr & ~done_m) | abort_g;  // see R10
    wire logic [NTX-1:0] arq_d   = (w_arq ? pwdata[NTX-1:0] & ~empty_q : arq_q)
                                 & ~abort_g & ~done_m;
    wire logic           ovr_d   = (ovr_q & ~(w_rxf & pwdata[`CMB_RXF_OVR])) | ovr_ev;
    // Buffer selection picks lowest requested empty buffer
    logic [1:0] sel_n;
    logic       sel_f;
    always_comb
    begin
        sel_n = 2'h0;
        sel_f = 1'b0;
        for (int i = NTX - 1; i >= 0; i--)
        begin
            if (pwdata[i] && empty_q[i])                            // see R3
            begin
                sel_n = 2'(i);
                sel_f = 1'b1;
            end
        end
    end
    // Control and mask registers
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ctrl_q <= `CMB_CTRL_RST;
            mask_q <= `CMB_MSK_RST;
        end
        else
        begin
            if (w_ctl)
                ctrl_q <= pwdata[2:0];
            if (w_msk)
                mask_q <= pwdata[2:0];
        end
    end
    // Transmit flags; init returns them to the reset picture
    always_ff @(posedge mclk)
    begin
        if (!nrst || init_m)
        begin
            empty_q  <= '1;                                         // see R24
            aak_q    <= '0;
            arq_q    <= '0;
            sel_q    <= 2'h0;
            sel_ok_q <= 1'b0;
        end
        else
        begin
            empty_q <= empty_d;
            aak_q   <= aak_d;
            arq_q   <= arq_d;
            if (w_sel)
            begin
                sel_q    <= sel_n;
                sel_ok_q <= sel_f;
            end
        end
    end
    // Transmit engine tracking
    always_ff @(posedge mclk)
    begin
        if (!nrst || init_m)
        begin
            tx_st_q <= TX_IDLE;
            act_q   <= 2'h0;
        end
        else
        begin
            case (tx_st_q)
                TX_IDLE:
                    // Arbitration attempt takes the current winner
                    if (arb_start && win_found)                     // see R8
                    begin
                        tx_st_q <= TX_BUSY;
                        act_q   <= win_idx;
                    end
                TX_BUSY:
                    // A fresh attempt reruns the choice; end frees it
                    if (arb_start)                                  // see R8
                    begin
                        tx_st_q <= win_found ? TX_BUSY : TX_IDLE;
                        act_q   <= win_idx;
                    end
                    else if (tx_end)
                        tx_st_q <= TX_IDLE;
                default:
                    tx_st_q <= TX_IDLE;
            endcase
        end
    end
    // Frame handed to the engine at arbitration
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            frame_q <= '0;
        else if (arb_start && win_found)
        begin
            for (int b = 0; b < `CMB_TX_FRAME; b++)
                frame_q[b*8 +: 8] <= txm[win_idx][b];               // see R2
        end
    end
    // Transmit buffer storage, no reset needed
    always_ff @(posedge mclk)
    begin
        if (w_txw)
            txm[sel_q][slot] <= pwdata[7:0];                        // see R4
        // Stamp after a sent frame
        if (tx_ok && time_en)                                       // see R23
        begin
            txm[act_q][`CMB_TX_STH] <= stamp_q[15:8];
            txm[act_q][`CMB_TX_STL] <= stamp_q[7:0];
        end
    end
    // Bit clock counter, cleared in init
    always_ff @(posedge mclk)
    begin
        if (!nrst || init_m)
            stamp_q <= '0;
        else if (bit_tick)
            stamp_q <= stamp_q + 16'h0001;
    end
    // Background buffer fills while the frame arrives
    always_ff @(posedge mclk)
    begin
        // Rejected frames are simply overwritten later
        if (rx_wr.we && rx_wr.idx < `CMB_RX_STH)                    // see R16 R17 R18
            bg[rx_wr.idx] <= rx_wr.data;
    end

    // FIFO storage: background copied in on a push
    always_ff @(posedge mclk)
    begin
        if (push)                                                   // see R11 R14
        begin
            for (int b = 0; b < `CMB_RX_STH; b++)
                fifo[wr_q][b] <= bg[b];
            // Stamp bytes left stale when stamping is off
            if (time_en)                                            // see R12 R23
            begin
                fifo[wr_q][`CMB_RX_STH] <= stamp_q[15:8];
                fifo[wr_q][`CMB_RX_STL] <= stamp_q[7:0];
            end
        end
    end

    // FIFO pointers and overrun
    always_ff @(posedge mclk)
    begin
        if (!nrst || init_m)
        begin
            rd_q  <= '0;                                            // see R24
            wr_q  <= '0;
            cnt_q <= '0;
            ovr_q <= 1'b0;
        end
        else
        begin
            ovr_q <= ovr_d;                                         // see R21
            if (push)
                wr_q <= (wr_q == PW'(RX_DEPTH - 1)) ? '0 : wr_q + PW'(1);
            if (pop)
                rd_q <= (rd_q == PW'(RX_DEPTH - 1)) ? '0 : rd_q + PW'(1);
            // Release of a slot reopens the receiver at once
            if (push && !pop)
                cnt_q <= cnt_q + (PW+1)'(1);                        // see R22
            else if (pop && !push)
                cnt_q <= cnt_q - (PW+1)'(1);
        end
    end

    // Read multiplexer
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctl)
            rd_mux[2:0] = ctrl_q;
        else if (hit_rxf)
        begin
            rd_mux[`CMB_RXF_FULL] = rx_full;
            rd_mux[`CMB_RXF_OVR]  = ovr_q;
        end
        else if (hit_txf)
            rd_mux[NTX-1:0] = empty_q;
        else if (hit_sel)
            rd_mux[NTX-1:0] = sel_ok_q ? NTX'(1) << sel_q : '0;
        else if (hit_arq)
            rd_mux[NTX-1:0] = arq_q;
        else if (hit_aak)
            rd_mux[NTX-1:0] = aak_q;
        else if (hit_msk)
            rd_mux[2:0] = mask_q;
        else if (hit_txw && win_ok)
            rd_mux[7:0] = txm[sel_q][slot];
        else if (hit_rxw && rx_full)                                // see R11
            rd_mux[7:0] = fifo[rd_q][slot];
    end

    // Read data captured in the setup cycle
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q <= rd_mux;
            err_q   <= ~mapped;
        end
    end

    // APB answer: one access cycle, no wait
    assign prdata   = rdata_q;
    assign pslverr  = err_q & psel & penable;
    assign pready   = 1'b1;
    // Engine outputs
    assign tx_req   = win_found;
    assign tx_index = act_q;
    assign tx_frame = frame_q;
    // Event lines, levels while flags stand
    assign tx_irq  = mask_q[`CMB_MSK_TX] & |empty_q;                // see R5 R10
    assign rx_irq  = mask_q[`CMB_MSK_RX] & rx_full;                 // see R14
    assign ovr_irq = mask_q[`CMB_MSK_OVR] & ovr_q;                  // see R21
endmodule : cmb_top
`default_nettype wire

/* File: rtl/cmb_cfg.svh */
`ifndef CMB_CFG_SVH
`define CMB_CFG_SVH
// Register byte offsets (low address byte)
`define CMB_A_CTRL   8'h00
`define CMB_A_RXFLG  8'h04
`define CMB_A_TXFLG  8'h08
`define CMB_A_TBSEL  8'h0C
`define CMB_A_ARQ    8'h10
`define CMB_A_AAK    8'h14
`define CMB_A_MASK   8'h18
// Window regions on address bits 7:6
`define CMB_R_TXWIN  2'h1
`define CMB_R_RXWIN  2'h2
// Control bits
`define CMB_CTRL_LOOP 0
`define CMB_CTRL_TIME 1
`define CMB_CTRL_INIT 2
`define CMB_CTRL_RST  3'h0
// Receive flag bits
`define CMB_RXF_FULL 0
`define CMB_RXF_OVR  1
// Mask bits
`define CMB_MSK_TX   0
`define CMB_MSK_RX   1
`define CMB_MSK_OVR  2
`define CMB_MSK_RST  3'h0
// Transmit window byte slots
`define CMB_TX_FRAME 13
`define CMB_TX_LOCAL_PRIORITY  4'hD
`define CMB_TX_STH   4'hE
`define CMB_TX_STL   4'hF
// Receive buffer byte slots
`define CMB_RX_BYTES 15
`define CMB_RX_STH   4'hD
`define CMB_RX_STL   4'hE
`endif

/* File: rtl/cmb_pkg.sv */
`default_nettype none
package cmb_pkg;
    // Transmit engine view
    typedef enum logic {TX_IDLE, TX_BUSY} cmb_tx_e;
    // Byte write into the background buffer
    typedef struct packed {
        logic       we;
        logic [3:0] idx;
        logic [7:0] data;
    } cmb_rxw_s;
    // End of a received frame
    typedef struct packed {
        logic valid;
        logic ok;
        logic accept;
        logic own;
    } cmb_rx_end_s;
    typedef logic [7:0] cmb_byte_t;
endpackage : cmb_pkg
`default_nettype wire

/* File: bench/cmb_monitor.sv */
`default_nettype none
module cmb_monitor
    import cmb_pkg::*;
(
    // Clock and reset
    input wire logic         mclk,
    input wire logic         nrst,
    // Bus strobes
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    // Engine side
    input wire logic         arb_start,
    input wire logic         tx_done,
    input wire logic         tx_lost,
    input wire logic         tx_error,
    input wire logic         tx_req,
    input wire logic [1:0]   tx_index,
    input wire logic [103:0] tx_frame,
    input wire cmb_rx_end_s  rx_end,
    input wire logic         loopback,
    // Event lines
    input wire logic         tx_irq,
    input wire logic         rx_irq,
    input wire logic         ovr_irq
);
    // Completed register write
    wire logic wr = psel && penable && pwrite;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Own frame outside loopback, nothing else moving
    sequence s_own_end;
        rx_end.valid && rx_end.own && !loopback && !rx_irq && !wr;
    endsequence
    // Errored or rejected frame
    sequence s_bad_end;
        rx_end.valid && !(rx_end.ok && rx_end.accept) && !rx_irq && !wr;
    endsequence

    AST_RST_CLEAN: assert property ($rose(nrst) |-> !tx_req && !tx_irq && !rx_irq && !ovr_irq)
        else $error("event lines not clear after reset");
    AST_IDX_RANGE: assert property (tx_index != 2'h3)
        else $error("transmit index outside three buffers");
    AST_FRAME_HOLD: assert property (!arb_start |=> $stable(tx_frame) && $stable(tx_index))
        else $error("winner changed without arbitration");
    AST_OWN_DROP: assert property (s_own_end |=> !rx_irq)
        else $error("own frame raised receive event");
    AST_BAD_DROP: assert property (s_bad_end |=> !rx_irq)
        else $error("invalid frame raised receive event");
    AST_OVR_CAUSE: assert property ($rose(ovr_irq) |-> $past(rx_end.valid) || $past(wr))
        else $error("overrun without a frame end");
    AST_TXIRQ_CAUSE: assert property ($rose(tx_irq) |-> $past(tx_done) || $past(wr) || $past(wr, 2)
        || $past(tx_lost, 2) || $past(tx_error, 2))
        else $error("transmit event without send or abort");
    AST_LOOP_HOLD: assert property (!wr |=> $stable(loopback))
        else $error("loopback changed without a write");
endmodule : cmb_monitor

bind cmb_top cmb_monitor u_mon (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .arb_start(arb_start), .tx_done(tx_done), .tx_lost(tx_lost), .tx_error(tx_error),
    .tx_req(tx_req), .tx_index(tx_index), .tx_frame(tx_frame), .rx_end(rx_end),
    .loopback(loopback), .tx_irq(tx_irq), .rx_irq(rx_irq), .ovr_irq(ovr_irq)
);
`default_nettype wire

/* File: bench/cmb_can_node.sv */
`default_nettype none
module cmb_can_node
    import cmb_pkg::*;
(
    // Clock
    input wire logic     mclk,
    // Transmit engine
    output logic         arb_start,
    output logic         tx_done,
    output logic         tx_lost,
    output logic         tx_error,
    // Receive engine
    output var cmb_rxw_s    rx_wr,
    output var cmb_rx_end_s rx_end,
    output logic         bit_tick
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet lines at time zero
    initial
    begin
        {arb_start, tx_done, tx_lost, tx_error, bit_tick} = 5'h00;
        rx_wr = '0;
        rx_end = '0;
    end

    // One arbitration attempt, the block picks again each time
    task automatic arb();
        @(posedge mclk) arb_start <= 1'b1;
        @(posedge mclk) arb_start <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : arb

    // Outcome: 1 sent, 2 lost, 3 error
    task automatic fin(input int kind);
        @(posedge mclk) {tx_done, tx_lost, tx_error} <= {kind == 1, kind == 2, kind == 3};
        @(posedge mclk) {tx_done, tx_lost, tx_error} <= 3'h0;
        @(posedge mclk);
    endtask : fin

    // Frame of 13 bytes; byte 0 carries a tag, byte i holds i
    task automatic frame(input logic [7:0] b0, input logic ok, input logic acc, input logic own);
        for (int i = 0; i < 13; i++)
        begin
            @(posedge mclk) rx_wr <= '{1'b1, 4'(i), (i == 0) ? b0 : 8'(i)};
        end
        // Released data line shows a changed pattern, not the last byte
        @(posedge mclk) rx_wr <= '{1'b0, 4'hF, ~rx_wr.data};
        rx_end <= '{1'b1, ok, acc, own};
        @(posedge mclk) rx_end <= '0;
        // Next frame may follow at once; three bit times pass meanwhile
        repeat (3)
        begin
            @(posedge mclk) bit_tick <= 1'b1;
            @(posedge mclk) bit_tick <= 1'b0;
        end
    endtask : frame
endmodule : cmb_can_node
`default_nettype wire

/* File: bench/tb_top.sv */
`include "cmb_cfg.svh"
`default_nettype none
module tb_top
    import cmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, nrst, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, serr;
    logic        arb_start, tx_done, tx_lost, tx_error, tx_req, bit_tick, loopback;
    logic        tx_irq, rx_irq, ovr_irq;
    logic [1:0]  tx_index;
    logic [103:0] tx_frame;
    cmb_rxw_s    rx_wr;
    cmb_rx_end_s rx_end;
    int          fail_count = 0;
    int          checks = 0;

    cmb_top dut (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .arb_start(arb_start), .tx_done(tx_done), .tx_lost(tx_lost), .tx_error(tx_error),
        .tx_req(tx_req), .tx_index(tx_index), .tx_frame(tx_frame), .rx_wr(rx_wr),
        .rx_end(rx_end), .bit_tick(bit_tick), .loopback(loopback), .tx_irq(tx_irq),
        .rx_irq(rx_irq), .ovr_irq(ovr_irq));
    cmb_can_node node (.mclk(mclk), .arb_start(arb_start), .tx_done(tx_done), .tx_lost(tx_lost),
        .tx_error(tx_error), .rx_wr(rx_wr), .rx_end(rx_end), .bit_tick(bit_tick));

    // 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic conclude();
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; the wait on pready is bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge mclk) penable <= 1'b1;
        n = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 16)
        begin
            fail_count++;
            conclude();
        end
        rd = prdata;
        serr = pslverr;
        {psel, penable} <= 2'h0;
        // Let this edge's updates settle before callers look at outputs
        #1;
    endtask : apb

    // Map a buffer, set its priority and first byte
    task automatic load(input int b, input logic [7:0] pri, input logic [7:0] b0);
        apb(1'b1, `CMB_A_TBSEL, 32'(1 << b));
        apb(1'b1, 8'h74, {24'h0, pri});
        // Every frame byte written, so no unknown reaches the engine
        for (int i = 0; i < `CMB_TX_FRAME; i++)
            apb(1'b1, 8'h40 + 8'(4 * i), {24'h0, (i == 0) ? b0 : 8'(i)});
    endtask : load

    task automatic t_reset();
        apb(1'b0, `CMB_A_TXFLG, 32'h0);
        chk("tx empty", rd, 32'h7);
        apb(1'b0, `CMB_A_RXFLG, 32'h0);
        chk("rx flags", rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", {31'h0, serr}, 32'h1);
        apb(1'b1, `CMB_A_MASK, 32'h7);
    endtask : t_reset

    task automatic t_local_priority();
        load(0, 8'h05, 8'hA0);
        load(1, 8'h02, 8'hA1);
        load(2, 8'h02, 8'hA2);
        apb(1'b1, `CMB_A_TXFLG, 32'h7);
        chk("tx irq busy", {31'h0, tx_irq}, 32'h0);
        chk("tx req", {31'h0, tx_req}, 32'h1);
        node.arb();
        chk("tie index", {30'h0, tx_index}, 32'h1);
        chk("frame byte", {24'h0, tx_frame[7:0]}, 32'hA1);
        chk("frame tail", {24'h0, tx_frame[103:96]}, 32'h0C);
        node.fin(3);
        node.arb();
        node.fin(1);
        apb(1'b0, `CMB_A_TXFLG, 32'h0);
        chk("sent empty", rd, 32'h2);
        chk("tx irq", {31'h0, tx_irq}, 32'h1);
        node.arb();
        chk("lowest local_priority", {30'h0, tx_index}, 32'h2);
        node.fin(2);
        node.frame(8'h55, 1'b1, 1'b1, 1'b0);
        apb(1'b0, 8'h80, 32'h0);
        chk("winner frame", rd, 32'h55);
        apb(1'b1, `CMB_A_RXFLG, 32'h1);
        node.arb();
        node.fin(1);
        node.arb();
        chk("last buffer", {30'h0, tx_index}, 32'h0);
        node.fin(1);
        apb(1'b0, `CMB_A_AAK, 32'h0);
        chk("sent ack", rd, 32'h0);
    endtask : t_local_priority

    task automatic t_abort();
        load(0, 8'h00, 8'hB0);
        load(1, 8'h01, 8'hB1);
        load(2, 8'h02, 8'hB2);
        apb(1'b1, `CMB_A_TXFLG, 32'h7);
        node.arb();
        apb(1'b1, `CMB_A_ARQ, 32'h7);
        apb(1'b0, `CMB_A_AAK, 32'h0);
        chk("abort ack", rd, 32'h6);
        apb(1'b0, `CMB_A_TXFLG, 32'h0);
        chk("abort empty", rd, 32'h6);
        chk("abort irq", {31'h0, tx_irq}, 32'h1);
        node.fin(1);
        apb(1'b0, `CMB_A_TXFLG, 32'h0);
        chk("busy sent", rd, 32'h7);
    endtask : t_abort

    task automatic t_rx();
        logic [7:0] prev;
        apb(1'b1, `CMB_A_CTRL, 32'h2);
        node.frame(8'h21, 1'b0, 1'b1, 1'b0);
        node.frame(8'h22, 1'b1, 1'b0, 1'b0);
        node.frame(8'h23, 1'b1, 1'b1, 1'b1);
        apb(1'b0, `CMB_A_RXFLG, 32'h0);
        chk("dropped", rd, 32'h0);
        for (int k = 1; k < 6; k++)
            node.frame(8'(k), 1'b1, 1'b1, 1'b0);
        chk("rx irq", {31'h0, rx_irq}, 32'h1);
        node.frame(8'h66, 1'b1, 1'b1, 1'b0);
        apb(1'b0, `CMB_A_RXFLG, 32'h0);
        chk("overrun", rd, 32'h3);
        chk("ovr irq", {31'h0, ovr_irq}, 32'h1);
        apb(1'b0, 8'h80, 32'h0);
        chk("head", rd, 32'h1);
        apb(1'b1, `CMB_A_RXFLG, 32'h3);
        node.frame(8'h06, 1'b1, 1'b1, 1'b0);
        for (int k = 2; k < 7; k++)
        begin
            apb(1'b0, 8'h80, 32'h0);
            chk("fifo order", rd, 32'(k));
            apb(1'b0, 8'hB0, 32'h0);
            chk("last byte", rd, 32'hC);
            apb(1'b0, 8'hB8, 32'h0);
            if (k > 2 && k < 6)
                chk("stamp step", {24'h0, rd[7:0] - prev}, 32'h3);
            prev = rd[7:0];
            apb(1'b1, `CMB_A_RXFLG, 32'h1);
        end
        apb(1'b0, `CMB_A_RXFLG, 32'h0);
        chk("drained", rd, 32'h0);
        apb(1'b1, `CMB_A_CTRL, 32'h3);
        chk("loop pin", {31'h0, loopback}, 32'h1);
        node.frame(8'h09, 1'b1, 1'b1, 1'b1);
        apb(1'b0, 8'h80, 32'h0);
        chk("loopback", rd, 32'h9);
    endtask : t_rx

    // Init, then a reset in mid-run, each from a dirty state
    task automatic t_init_rst();
        apb(1'b1, `CMB_A_CTRL, 32'h4);
        apb(1'b0, `CMB_A_RXFLG, 32'h0);
        chk("init fifo", rd, 32'h0);
        apb(1'b1, `CMB_A_CTRL, 32'h3);
        node.frame(8'h0A, 1'b1, 1'b1, 1'b0);
        @(posedge mclk) nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b0, `CMB_A_RXFLG, 32'h0);
        chk("reset fifo", rd, 32'h0);
        chk("reset loop", {31'h0, loopback}, 32'h0);
        apb(1'b0, `CMB_A_TXFLG, 32'h0);
        chk("reset empty", rd, 32'h7);
    endtask : t_init_rst

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        // Write data left open until the first transfer drives it
        {psel, penable, pwrite, paddr} = '0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_local_priority();
        t_abort();
        t_rx();
        t_init_rst();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
